// ### test_watchdog_mode_write_lock.sv
`timescale 1ns/1ps
module test_watchdog_mode_write_lock;
  reg        i_core_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_bit_op = 0;
  reg  [3:0] i_addr = 4'h0;
  reg  [7:0] i_wdata = 8'h00, d, exp_st;
  wire [7:0] o_rdata, o_mode;
  wire       o_int_reset, o_key_clear, o_wd_stopped, o_irq;
  integer    errors = 0, checked = 0, seed = 26991, n;
  always #20 i_core_clk = ~i_core_clk;
  watchdog_mode_write_lock DUT (.*);
  task chk(input [7:0] s, e); begin
    checked = checked + 1;
    if (s !== e) begin errors = errors + 1; $display("CHECK FAILED %0t seen %h expected %h", $time, s, e); end
  end endtask
  task rs; begin i_rst <= 1; repeat (3) @(posedge i_core_clk); i_rst <= 0; end endtask
  task wr(input [3:0] a, input [7:0] v, input b, e); begin
    @(posedge i_core_clk); i_addr <= a; i_wdata <= v; i_bit_op <= b; i_wr <= 1;
    @(posedge i_core_clk); i_wr <= 0; #1 chk(o_int_reset, e);
  end endtask
  task rd(input [3:0] a, input [7:0] e); begin
    @(posedge i_core_clk); i_addr <= a; i_rd <= 1;
    @(posedge i_core_clk); i_rd <= 0; #1 chk(o_rdata, e);
  end endtask
  function bad(input [7:0] v); bad = v != 8'hAC; endfunction
  task end_sim; begin
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  // Watchdog
  initial begin #100000; errors = errors + 1; end_sim; end
  // Main sequence
  initial begin
    rs;
    rd(4'h1, 8'h9A);
    rd(4'hF, 8'h00);
    wr(4'h3, 8'h0F, 0, 0);
    exp_st = 8'h00;
    for (n = 0; n < 6; n = n + 1) begin
      d = n ? $random(seed) : 8'hAC;
      if (bad(d)) exp_st = exp_st | 8'h02;
      wr(4'h1, d, 0, bad(d));
      chk(o_key_clear, !bad(d));
    end
    rd(4'h2, exp_st);
    chk(o_irq, exp_st != 8'h00);
    wr(4'h2, 8'hFF, 0, 0);
    chk(o_irq, 0);
    wr(4'h1, 8'hAC, 1, 1);
    chk(o_key_clear, 0);
    wr(4'h0, 8'h60, 0, 0);
    chk(o_mode, 8'h60);
    chk(o_wd_stopped, 0);
    wr(4'h0, 8'h60, 0, 1);
    rd(4'h4, 8'h01);
    rs;
    #1 chk(o_mode, 8'h00);
    chk(o_rdata, 8'h00);
    wr(4'h0, 8'h70, 0, 0);
    chk(o_wd_stopped, 1);
    wr(4'h0, 8'h65, 0, 0);
    rd(4'h0, 8'h70);
    rd(4'h4, 8'h03);
    wr(4'h1, 8'hAC, 1, 0);
    chk(o_key_clear, 0);
    d = $random(seed) | 8'h01;
    wr(4'h1, d, 0, 0);
    rs;
    wr(4'h0, 8'h60, 1, 1);
    rd(4'h4, 8'h00);
    wr(4'h0, 8'h8F, 0, 0);
    rd(4'h2, 8'h0C);
    rd(4'h0, 8'h8F);
    wr(4'h3, 8'h04, 0, 0);
    chk(o_irq, 1);
    wr(4'h2, 8'h04, 0, 0);
    chk(o_irq, 0);
    rd(4'h2, 8'h08);
    end_sim;
  end
endmodule // test_watchdog_mode_write_lock

// ### watchdog_mode_write_lock.v
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "wd_guard_regs.vh"
// Behaviour
// - Mode register takes one byte write after reset.
// - Unless stopped, a second mode write forces an internal reset.
// - Stopped first-write setting makes later mode writes harmless.
// - When stopped, single-bit access to clear key causes no reset.
// - When stopped, wrong clear-key value causes no reset.
// - Normally, a wrong clear-key value forces internal reset.
// - Normally, single-bit access to clear key forces internal reset.
// - Clear-key register reads a fixed value unlike the key.
module watchdog_mode_write_lock (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst,
  // Register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire       i_bit_op,
  output reg  [7:0] o_rdata,
  // Guard outputs
  output reg        o_int_reset,
  output reg        o_key_clear,
  output wire       o_wd_stopped,
  output wire [7:0] o_mode,
  output wire       o_irq
);

  // Lock states: bit 0 marks the taken mode write, bit 1 the stopped choice.
  // Code 2'h2 is never entered; it falls back to the guarding state.
  localparam [1:0] ST_OPEN   = 2'h0;
  localparam [1:0] ST_ARMED  = 2'h1;
  localparam [1:0] ST_HALTED = 2'h3;

  // Mode register and lock state
  reg  [7:0] mode;
  reg  [1:0] lock_state;
  reg  [1:0] next_lock;

  // Interrupt status and mask
  reg  [3:0] irq_stat;
  reg  [3:0] irq_mask;
  reg  [3:0] stat_set;
  reg  [3:0] stat_clr;
  reg  [3:0] next_stat;

  // Read path
  reg  [7:0] next_rdata;

  // Strobe qualified by one register index
  function reg_hit(input strobe, input [3:0] addr, input [3:0] ofs);
    reg_hit = strobe & (addr == ofs);
  endfunction

  // Byte equal to the clear key
  function key_match(input [7:0] data);
    key_match = (data == `WD_KEY_CLEAR);
  endfunction

  // Upper mode bits carry the mandatory fixed pattern
  function pattern_ok(input [7:0] data);
    pattern_ok = (data[`WD_FIXED_HI:`WD_FIXED_LO] == `WD_FIXED_VAL);
  endfunction

  // Clock-select choice that stops the watchdog; the lower select bit is ignored
  function stop_choice(input [7:0] data);
    stop_choice = data[`WD_CS_HI_BIT];
  endfunction

  // Write-one-to-clear update; a fresh event beats a clear in the same cycle
  function [3:0] sticky_next(input [3:0] cur, input [3:0] clr, input [3:0] set);
    sticky_next = (cur & ~clr) | set;
  endfunction

  // Decoded write strobes
  wire       wr_mode      = reg_hit(i_wr, i_addr, `WD_MODE_OFS);
  wire       wr_key       = reg_hit(i_wr, i_addr, `WD_KEY_OFS);
  wire       wr_stat      = reg_hit(i_wr, i_addr, `WD_IRQ_STAT_OFS);
  wire       wr_mask      = reg_hit(i_wr, i_addr, `WD_IRQ_MASK_OFS);

  // Lock status read straight from the state flops
  wire       mode_written = lock_state[0];
  wire       stopped      = lock_state[1];

  // Byte and single-bit variants of the guarded writes
  wire       mode_byte    = wr_mode & ~i_bit_op;
  wire       key_byte     = wr_key & ~i_bit_op;
  wire       key_bit      = wr_key & i_bit_op;

  // The one mode write taken after reset; bit-op writes never count
  wire       first_take   = mode_byte & ~mode_written;

  // Violation events
  wire       ev_mode2     = wr_mode & mode_written & ~stopped;
  wire       ev_bitop_m   = wr_mode & ~mode_written & i_bit_op;
  wire       ev_keybad    = key_byte & ~key_match(i_wdata) & ~stopped;
  wire       ev_bitop_k   = key_bit & ~stopped;
  wire       ev_pat       = first_take & ~pattern_ok(i_wdata);

  // Events asking for an internal reset; a bad pattern only flags status,
  // so a careless boot write is reported without cycling the device
  wire       any_reset    = ev_mode2 | ev_bitop_m | ev_keybad | ev_bitop_k;

  // Correct key written as a byte
  wire       key_ok       = key_byte & key_match(i_wdata);

  // Outputs taken from flops
  assign o_wd_stopped = stopped;
  assign o_mode       = mode;
  assign o_irq        = |(irq_stat & irq_mask);

  // Lock sequence: open until the first byte write, then armed or halted for good.
  // Only reset leaves the armed or halted state, so no write can unlock the mode.
  always @* begin
    next_lock = lock_state;
    case (lock_state)
      ST_OPEN: begin
        if (first_take) begin
          if (stop_choice(i_wdata)) begin
            next_lock = ST_HALTED;
          end else begin
            next_lock = ST_ARMED;
          end
        end
      end
      ST_ARMED: begin
        next_lock = ST_ARMED;
      end
      ST_HALTED: begin
        next_lock = ST_HALTED;
      end
      default: begin
        next_lock = ST_ARMED;
      end
    endcase
  end

  // Events that set status bits this cycle
  always @* begin
    stat_set                 = 4'h0;
    stat_set[`WD_ST_MODE2]   = ev_mode2;
    stat_set[`WD_ST_KEYBAD]  = ev_keybad;
    stat_set[`WD_ST_BITOP]   = ev_bitop_k | ev_bitop_m;
    stat_set[`WD_ST_PATTERN] = ev_pat;
  end

  // Bits that software clears this cycle
  always @* begin
    stat_clr = 4'h0;
    if (wr_stat) begin
      stat_clr = i_wdata[3:0];
    end
  end

  // Next status, set wins over write-one clear
  always @* begin
    next_stat = sticky_next(irq_stat, stat_clr, stat_set);
  end

  // Read selection; idle cycles return zero
  always @* begin
    next_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `WD_MODE_OFS:     next_rdata = mode;
        `WD_KEY_OFS:      next_rdata = `WD_KEY_READ;
        `WD_IRQ_STAT_OFS: next_rdata = {4'h0, irq_stat};
        `WD_IRQ_MASK_OFS: next_rdata = {4'h0, irq_mask};
        `WD_FLAGS_OFS:    next_rdata = {6'h00, stopped, mode_written};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // Lock state register
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_state <= ST_OPEN;
    end else begin
      lock_state <= next_lock;
    end
  end

  // Mode value, stored only by the first byte write
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      mode <= `WD_MODE_RST;
    end else if (first_take) begin
      mode <= i_wdata;
    end
  end

  // Sticky interrupt status
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= next_stat;
    end
  end

  // Interrupt mask
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_mask <= 4'h0;
    end else if (wr_mask) begin
      irq_mask <= i_wdata[3:0];
    end
  end

  // Reset request and key-clear pulses, one cycle each
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_int_reset <= 1'h0;
      o_key_clear <= 1'h0;
    end else begin
      o_int_reset <= any_reset;
      o_key_clear <= key_ok;
    end
  end

  // Read data one cycle after the strobe
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // watchdog_mode_write_lock

// ### wd_guard_chk_sva.sv
`timescale 1ns/1ps
module wd_guard_chk (
  input wire       i_core_clk, i_rst, i_wr, i_rd, i_bit_op,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata, o_rdata, o_mode,
  input wire       o_int_reset, o_key_clear, o_wd_stopped
);
  reg  lk;
  wire mw = i_wr && i_addr == 4'h0;
  wire kw = i_wr && i_addr == 4'h1;
  // Lock after first byte mode write
  always @(posedge i_core_clk) lk <= i_rst ? 1'b0 : lk | (mw && !i_bit_op);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_key_read: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == 8'h9A)
    else $error("key read");
  chk_mode_held: assert property (lk |=> $stable(o_mode)) else $error("mode");
  chk_mode_first: assert property (mw && !i_bit_op && !lk |=>
    o_mode == $past(i_wdata) && o_wd_stopped == o_mode[4] && !o_int_reset) else $error("first");
  chk_mode_bitop: assert property (mw && i_bit_op && !lk |=> o_int_reset) else $error("bitop");
  chk_second_mode: assert property (mw && lk && !o_wd_stopped |=> o_int_reset) else $error("2nd");
  chk_key_bad: assert property (kw && !o_wd_stopped && (i_bit_op || i_wdata != 8'hAC) |=>
    o_int_reset) else $error("key");
  chk_stop_quiet: assert property (o_wd_stopped && (mw || kw) |=> !o_int_reset)
    else $error("stopped");
  chk_key_ok: assert property (kw && !i_bit_op && i_wdata == 8'hAC |=> o_key_clear) else $error("ok");
  cover property (mw && lk);
  cover property (o_wd_stopped && kw && i_bit_op);
  cover property (kw && o_int_reset);
endmodule // wd_guard_chk
bind watchdog_mode_write_lock wd_guard_chk u_chk (.*);

// ### wd_guard_regs.vh
`ifndef WD_GUARD_REGS_VH
`define WD_GUARD_REGS_VH
// Register offsets
`define WD_MODE_OFS        4'h0
`define WD_KEY_OFS         4'h1
`define WD_IRQ_STAT_OFS    4'h2
`define WD_IRQ_MASK_OFS    4'h3
`define WD_FLAGS_OFS       4'h4
// Mode register fields
`define WD_FIXED_HI        7
`define WD_FIXED_LO        5
`define WD_FIXED_VAL       3'h3
`define WD_CS_HI_BIT       4
`define WD_CS_LO_BIT       3
`define WD_MODE_RST        8'h00
// Clear key and read-back value
`define WD_KEY_CLEAR       8'hAC
`define WD_KEY_READ        8'h9A
// Status bit positions
`define WD_ST_MODE2        0
`define WD_ST_KEYBAD       1
`define WD_ST_BITOP        2
`define WD_ST_PATTERN      3
`endif
